// ### src/pmef_pkg.sv
// Summary of operation
// - Flag bit 7 sets when the rail source returns from battery to main.
// - Flag bit 6 sets when any enabled supply event occurs.
// - Flag bit 5 sets on a line voltage sag report.
// - Flag bit 3 sets on rail delta or new rail measurement.
// - Flag bit 2 sets on battery below threshold or new battery measurement.
// - Flag bit 1 sets when the rail source moves from main to battery.
// - Flag bit 0 sets on DC input low; all flags reset to zero.
// - Policy 00 main low, 01 main or DC low, 1X switchover off.
// - Peripheral bit 7 sets when a receive edge wakes from battery sleep.
// - Peripheral bit 6 shows rail source, 1 main, resets to 1.
// - Peripheral bit 5 reads 1 while main supply is adequate, resets 1.
// - Peripheral bit 4 reads 1 while PLL is unlocked, resets 0.
// - Peripheral bit 3 keeps reference on in battery sleep mode.
// - Receive function 00 GPIO, 01 serial no wake, 11 serial with wake.
// - Enable bits 7,5,3,2,1,0 gate matching flags onto the interrupt.
// - Enable bit 6 makes measurement status reads clear-on-read.
// - Flag register sits at special function address F8.
package pmef_pkg;

  // ----------------------------------------
  // Special function addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_ENABLE = 8'hEC;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_STATUS = 8'hF4;
  localparam logic [7:0] ADDR_CONFIG = 8'hF5;
  localparam logic [7:0] ADDR_FLAGS  = 8'hF8;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FLG_RESTORED = 7;
  localparam int FLG_SUMMARY  = 6;
  localparam int FLG_SAG      = 5;
  localparam int FLG_RESV     = 4;
  localparam int FLG_RAIL     = 3;
  localparam int FLG_BATTERY  = 2;
  localparam int FLG_SWITCH   = 1;
  localparam int FLG_DC       = 0;
  localparam int EN_READ_CLR  = 6;
  localparam int PER_RX_WAKE  = 7;
  localparam int PER_SOURCE   = 6;
  localparam int PER_MAIN_OK  = 5;
  localparam int PER_PLL      = 4;
  localparam int PER_REF_EN   = 3;
  localparam int PER_RESV     = 2;
  localparam int POL_OFF_BIT  = 1;
  localparam int NUM_FLAGS    = 8;

  // ----------------------------------------
  // Codes and masks
  // ----------------------------------------
  localparam logic [7:0] IRQ_EN_MASK  = 8'hAF;
  localparam logic [1:0] POL_MAIN     = 2'h0;
  localparam logic [1:0] POL_MAIN_DC  = 2'h1;
  localparam logic [1:0] RX_GPIO      = 2'h0;
  localparam logic [1:0] RX_SERIAL    = 2'h1;
  localparam logic [1:0] RX_WAKE      = 2'h3;
  localparam logic [7:0] RDATA_NONE   = 8'h00;
  localparam logic [7:0] FLAGS_RST    = 8'h00;
  localparam logic [7:0] ENABLE_RST   = 8'h00;
  localparam logic [7:0] CONFIG_RST   = 8'h00;

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] config_reg;
    logic       rx_wake;
    logic       rail_main;
    logic       main_ok;
    logic       pll_unlocked;
    logic       ref_en;
    logic       resv2;
    logic [1:0] rx_func;
    logic [7:0] rdata;
  } pmef_state_t;

  localparam pmef_state_t STATE_RST = '{
    enable:       ENABLE_RST,
    config_reg:   CONFIG_RST,
    rx_wake:      1'b0,
    rail_main:    1'b1,
    main_ok:      1'b1,
    pll_unlocked: 1'b0,
    ref_en:       1'b0,
    resv2:        1'b0,
    rx_func:      RX_GPIO,
    rdata:        RDATA_NONE
  };

  typedef struct packed {
    logic q;
  } pmef_flag_t;

endpackage

// ### src/pmef_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
module pmef_flag_bit (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic wr,
  input  wire logic wdata,
  output logic      q
);

  pmef_pkg::pmef_flag_t st;
  pmef_pkg::pmef_flag_t next_st;

  // Hardware set beats a software clear in the same cycle
  always_comb begin
    next_st = st;
    if (ce) begin
      if (set) begin
        next_st.q = 1'b1;
      end else if (wr) begin
        next_st.q = wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

  set_wins_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && set |=> q) else $error("flag lost a set");
  hold_a: assert property (@(posedge clk) disable iff (!nrst)
    q && !(ce && wr && !wdata) |=> q) else $error("flag dropped without clear");

endmodule
`default_nettype wire

// ### src/pmef_sfr_decode.sv
`timescale 1ns/1ps
`default_nettype none
module pmef_sfr_decode (
  input  wire logic [7:0] addr,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic       bit_wr,
  input  wire logic [7:0] bit_addr,
  input  wire logic       bit_wdata,
  output logic            sel_enable,
  output logic            sel_peripheral_config_status,
  output logic            sel_config,
  output logic [7:0]      flag_wr,
  output logic [7:0]      flag_val
);

  logic flag_byte;
  logic flag_bits;

  assign sel_enable = wr && (addr == pmef_pkg::ADDR_ENABLE);
  assign sel_peripheral_config_status = wr && (addr == pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS);
  assign sel_config = wr && (addr == pmef_pkg::ADDR_CONFIG);
  assign flag_byte  = wr && (addr == pmef_pkg::ADDR_FLAGS);
  // Flag register is bit addressable from F8 upward
  assign flag_bits  = bit_wr && (bit_addr[7:3] == pmef_pkg::ADDR_FLAGS[7:3]);

  // Byte write wins if both strobes fire together
  always_comb begin
    flag_wr  = '0;
    flag_val = wdata;
    if (flag_byte) begin
      flag_wr = '1;
    end else if (flag_bits) begin
      flag_wr[bit_addr[2:0]]  = 1'b1;
      flag_val[bit_addr[2:0]] = bit_wdata;
    end
  end

endmodule
`default_nettype wire

// ### src/pmef_top.sv
`timescale 1ns/1ps
`default_nettype none
module pmef_top (
  input  wire logic       CORE_CLK,
  input  wire logic       NRST,
  input  wire logic       CORE_CE,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       BIT_WR,
  input  wire logic [7:0] BIT_ADDR,
  input  wire logic       BIT_WDATA,
  input  wire logic       RAIL_ON_MAIN,
  input  wire logic       MAIN_SUPPLY_OK,
  input  wire logic       PLL_UNLOCKED,
  input  wire logic       SAG_EVT,
  input  wire logic       RAIL_DELTA_EVT,
  input  wire logic       RAIL_MEAS_RDY,
  input  wire logic       BATTERY_LOW_EVT,
  input  wire logic       BATTERY_MEAS_RDY,
  input  wire logic       DC_INPUT_LOW_EVT,
  input  wire logic       RX_EDGE_WAKE_EVT,
  output logic            SUPPLY_IRQ,
  output logic            MEAS_STATUS_READ_CLEAR,
  output logic            SWITCH_ON_MAIN_LOW,
  output logic            SWITCH_ON_DC_LOW,
  output logic            SLEEP_REF_EN,
  output logic            RX_PIN_GPIO,
  output logic            RX_PIN_SERIAL,
  output logic            RX_WAKE_EN
);

  pmef_pkg::pmef_state_t st;
  pmef_pkg::pmef_state_t next_st;

  logic       sel_enable;
  logic       sel_peripheral_config_status;
  logic       sel_config;
  logic [7:0] flag_wr;
  logic [7:0] flag_val;
  logic [7:0] flags;
  logic [7:0] evt_raw;
  logic [7:0] evt_set;
  logic       any_enabled_evt;
  logic [7:0] peripheral_config_status_view;
  logic [7:0] gated;

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  pmef_sfr_decode u_decode (
    .addr       (SFR_ADDR),
    .wr         (SFR_WR),
    .wdata      (SFR_WDATA),
    .bit_wr     (BIT_WR),
    .bit_addr   (BIT_ADDR),
    .bit_wdata  (BIT_WDATA),
    .sel_enable (sel_enable),
    .sel_peripheral_config_status (sel_peripheral_config_status),
    .sel_config (sel_config),
    .flag_wr    (flag_wr),
    .flag_val   (flag_val)
  );

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  // Source edges compare against the registered rail level, which resets
  // to main so a board that powers up on main raises nothing.
  always_comb begin
    evt_raw = '0;
    evt_raw[pmef_pkg::FLG_RESTORED] = !st.rail_main && RAIL_ON_MAIN;
    evt_raw[pmef_pkg::FLG_SAG]      = SAG_EVT;
    evt_raw[pmef_pkg::FLG_RAIL]     = RAIL_DELTA_EVT || RAIL_MEAS_RDY;
    evt_raw[pmef_pkg::FLG_BATTERY]  = BATTERY_LOW_EVT || BATTERY_MEAS_RDY;
    evt_raw[pmef_pkg::FLG_SWITCH]   = st.rail_main && !RAIL_ON_MAIN;
    evt_raw[pmef_pkg::FLG_DC]       = DC_INPUT_LOW_EVT;
  end

  // Summary only counts events whose enable is set; bit 6 of the enable
  // register is a read-clear control, not an enable, so it is masked.
  assign any_enabled_evt = |(evt_raw & st.enable & pmef_pkg::IRQ_EN_MASK);

  always_comb begin
    evt_set = evt_raw;
    evt_set[pmef_pkg::FLG_SUMMARY] = any_enabled_evt;
  end

  // ----------------------------------------
  // Sticky flags
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < pmef_pkg::NUM_FLAGS; i++) begin : g_flag
      pmef_flag_bit u_flag (
        .clk   (CORE_CLK),
        .nrst  (NRST),
        .ce    (CORE_CE),
        .set   (evt_set[i]),
        .wr    (flag_wr[i]),
        .wdata (flag_val[i]),
        .q     (flags[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // Peripheral status view
  // ----------------------------------------
  always_comb begin
    peripheral_config_status_view = '0;
    peripheral_config_status_view[pmef_pkg::PER_RX_WAKE] = st.rx_wake;
    peripheral_config_status_view[pmef_pkg::PER_SOURCE]  = st.rail_main;
    peripheral_config_status_view[pmef_pkg::PER_MAIN_OK] = st.main_ok;
    peripheral_config_status_view[pmef_pkg::PER_PLL]     = st.pll_unlocked;
    peripheral_config_status_view[pmef_pkg::PER_REF_EN]  = st.ref_en;
    peripheral_config_status_view[pmef_pkg::PER_RESV]    = st.resv2;
    peripheral_config_status_view[1:0]                   = st.rx_func;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (CORE_CE) begin
      next_st.rail_main    = RAIL_ON_MAIN;
      next_st.main_ok      = MAIN_SUPPLY_OK;
      next_st.pll_unlocked = PLL_UNLOCKED;
      if (sel_enable) begin
        // Reserved bit 4 is stored as written; software keeps it zero
        next_st.enable = SFR_WDATA;
      end
      if (sel_config) begin
        next_st.config_reg = SFR_WDATA;
      end
      if (sel_peripheral_config_status) begin
        // Only a zero clears the wake flag; a one is ignored
        if (!SFR_WDATA[pmef_pkg::PER_RX_WAKE]) begin
          next_st.rx_wake = 1'b0;
        end
        next_st.ref_en  = SFR_WDATA[pmef_pkg::PER_REF_EN];
        next_st.resv2   = SFR_WDATA[pmef_pkg::PER_RESV];
        next_st.rx_func = SFR_WDATA[1:0];
      end
      // Wake edge only counts when wake-up is armed; it beats a clear
      if (RX_EDGE_WAKE_EVT && st.rx_func == pmef_pkg::RX_WAKE) begin
        next_st.rx_wake = 1'b1;
      end
      // Read data is captured on the strobe, one cycle of latency
      if (SFR_RD) begin
        unique case (SFR_ADDR)
          pmef_pkg::ADDR_ENABLE: next_st.rdata = st.enable;
          pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS: next_st.rdata = peripheral_config_status_view;
          pmef_pkg::ADDR_CONFIG: next_st.rdata = st.config_reg;
          pmef_pkg::ADDR_FLAGS:  next_st.rdata = flags;
          default:               next_st.rdata = pmef_pkg::RDATA_NONE;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st <= pmef_pkg::STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign gated                  = flags & st.enable & pmef_pkg::IRQ_EN_MASK;
  assign SUPPLY_IRQ             = |gated;
  assign MEAS_STATUS_READ_CLEAR = st.enable[pmef_pkg::EN_READ_CLR];
  // Upper policy bit disables switchover whatever the lower bit says
  assign SWITCH_ON_MAIN_LOW     = !st.config_reg[pmef_pkg::POL_OFF_BIT];
  assign SWITCH_ON_DC_LOW       = (st.config_reg[1:0] == pmef_pkg::POL_MAIN_DC);
  assign SLEEP_REF_EN           = st.ref_en;
  assign RX_PIN_GPIO            = (st.rx_func == pmef_pkg::RX_GPIO);
  // Code 10 is undefined; it is treated as serial without wake
  assign RX_PIN_SERIAL          = (st.rx_func != pmef_pkg::RX_GPIO);
  assign RX_WAKE_EN             = (st.rx_func == pmef_pkg::RX_WAKE);
  assign SFR_RDATA              = st.rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  restored_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && !st.rail_main && RAIL_ON_MAIN |=> flags[pmef_pkg::FLG_RESTORED])
    else $error("restored flag not set");

  summary_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && SAG_EVT && st.enable[pmef_pkg::FLG_SAG] |=> flags[pmef_pkg::FLG_SUMMARY])
    else $error("summary flag not set");

  sag_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && SAG_EVT |=> flags[pmef_pkg::FLG_SAG])
    else $error("sag flag not set");

  rail_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && (RAIL_DELTA_EVT || RAIL_MEAS_RDY) |=> flags[pmef_pkg::FLG_RAIL])
    else $error("rail flag not set");

  battery_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && (BATTERY_LOW_EVT || BATTERY_MEAS_RDY) |=> flags[pmef_pkg::FLG_BATTERY])
    else $error("battery flag not set");

  switchover_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && st.rail_main && !RAIL_ON_MAIN |=> flags[pmef_pkg::FLG_SWITCH])
    else $error("switchover flag not set");

  dc_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && DC_INPUT_LOW_EVT |=> flags[pmef_pkg::FLG_DC])
    else $error("dc flag not set");

  policy_off_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && sel_config && SFR_WDATA[pmef_pkg::POL_OFF_BIT]
    |=> !SWITCH_ON_MAIN_LOW && !SWITCH_ON_DC_LOW)
    else $error("switchover not disabled");

  rx_wake_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && RX_EDGE_WAKE_EVT && RX_WAKE_EN |=> st.rx_wake)
    else $error("wake flag not set");

  source_read_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && SFR_RD && SFR_ADDR == pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS
    |=> SFR_RDATA[pmef_pkg::PER_SOURCE] == $past(st.rail_main))
    else $error("source status wrong");

  pll_track_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE |=> st.pll_unlocked == $past(PLL_UNLOCKED))
    else $error("pll status stale");

  irq_gate_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && sel_enable && SFR_WDATA == pmef_pkg::ENABLE_RST |=> !SUPPLY_IRQ)
    else $error("irq without enable");

  irq_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    SUPPLY_IRQ && !CORE_CE |=> SUPPLY_IRQ)
    else $error("irq dropped while frozen");

  flag_read_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && SFR_RD && SFR_ADDR == pmef_pkg::ADDR_FLAGS |=> SFR_RDATA == $past(flags))
    else $error("flag read wrong");

  enable_read_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && SFR_RD && SFR_ADDR == pmef_pkg::ADDR_ENABLE |=> SFR_RDATA == $past(st.enable))
    else $error("enable read wrong");

  rdata_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !(CORE_CE && SFR_RD) |=> $stable(SFR_RDATA))
    else $error("read data moved without read");

  rail_track_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE |=> st.rail_main == $past(RAIL_ON_MAIN))
    else $error("rail source stale");

  main_ok_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE |=> st.main_ok == $past(MAIN_SUPPLY_OK))
    else $error("main supply status stale");

  wake_armed_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && !RX_WAKE_EN && !st.rx_wake |=> !st.rx_wake)
    else $error("wake flag set while unarmed");

  wake_clear_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && sel_peripheral_config_status && !SFR_WDATA[pmef_pkg::PER_RX_WAKE]
    && !(RX_EDGE_WAKE_EVT && RX_WAKE_EN) |=> !st.rx_wake)
    else $error("wake flag not cleared");

  ref_en_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && sel_peripheral_config_status |=> SLEEP_REF_EN == $past(SFR_WDATA[pmef_pkg::PER_REF_EN]))
    else $error("reference enable wrong");

  rx_func_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && sel_peripheral_config_status |=> st.rx_func == $past(SFR_WDATA[1:0]))
    else $error("receive function wrong");

  policy_dc_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && sel_config && SFR_WDATA[1:0] == pmef_pkg::POL_MAIN_DC
    |=> SWITCH_ON_MAIN_LOW && SWITCH_ON_DC_LOW)
    else $error("dc policy wrong");

  policy_main_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && sel_config && SFR_WDATA[1:0] == pmef_pkg::POL_MAIN
    |=> SWITCH_ON_MAIN_LOW && !SWITCH_ON_DC_LOW)
    else $error("main policy wrong");

  read_clear_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && sel_enable
    |=> MEAS_STATUS_READ_CLEAR == $past(SFR_WDATA[pmef_pkg::EN_READ_CLR]))
    else $error("read clear control wrong");

  flag_freeze_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !CORE_CE |=> flags == $past(flags))
    else $error("flags moved while frozen");

  clear_lands_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CORE_CE && SFR_WR && SFR_ADDR == pmef_pkg::ADDR_FLAGS
    && SFR_WDATA == pmef_pkg::FLAGS_RST && evt_set == '0 |=> flags == pmef_pkg::FLAGS_RST)
    else $error("flag clear lost");

  irq_none_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    flags == pmef_pkg::FLAGS_RST |-> !SUPPLY_IRQ)
    else $error("irq without flags");

  // One check per interrupt-capable flag; bit 6 is a control, not a source
  genvar j;
  generate
    for (j = 0; j < pmef_pkg::NUM_FLAGS; j++) begin : g_irq_chk
      if (pmef_pkg::IRQ_EN_MASK[j]) begin : g_en
        irq_raise_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
          flags[j] && st.enable[j] |-> SUPPLY_IRQ)
          else $error("enabled flag without irq");
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### tb/pmef_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmef_core_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic            wr,
  output logic            rd,
  output logic      [7:0] wdata,
  output logic            bit_wr,
  output logic      [7:0] bit_addr,
  output logic            bit_wdata
);
  initial begin
    addr = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    wdata = 8'h00;
    bit_wr = 1'h0;
    bit_addr = 8'h00;
    bit_wdata = 1'h0;
  end

  // ----------------------------------------
  // Software never sets reserved bits
  // ----------------------------------------
  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    case (a)
      pmef_pkg::ADDR_CONFIG: keep_mask = 8'h03;
      pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS: keep_mask = 8'hFB;
      default:               keep_mask = 8'hEF;
    endcase
  endfunction

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d & keep_mask(a);
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    // Released data shows the inverse so a stale value is never trusted
    wdata <= ~(d & keep_mask(a));
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic write_bit(input logic [2:0] b, input logic v);
    @(posedge clk);
    bit_addr <= pmef_pkg::ADDR_FLAGS | {5'h00, b};
    bit_wdata <= v;
    bit_wr <= 1'h1;
    @(posedge clk);
    bit_wr <= 1'h0;
    bit_wdata <= ~v;
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk;
  logic       nrst;
  logic       ce;
  logic [7:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       bit_wr;
  logic [7:0] bit_addr;
  logic       bit_wdata;
  logic       rail;
  logic       main_ok;
  logic       pll;
  logic [6:0] evt;
  logic       irq;
  logic       rd_clr;
  logic       sw_main;
  logic       sw_dc;
  logic       ref_en;
  logic       rx_gpio;
  logic       rx_serial;
  logic       rx_wake;
  logic [7:0] v;
  int         errors;
  int         tests_run;

  pmef_top pmef_top_inst (
    .CORE_CLK(clk), .NRST(nrst), .CORE_CE(ce), .SFR_ADDR(addr), .SFR_WR(wr),
    .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .BIT_WR(bit_wr),
    .BIT_ADDR(bit_addr), .BIT_WDATA(bit_wdata), .RAIL_ON_MAIN(rail),
    .MAIN_SUPPLY_OK(main_ok), .PLL_UNLOCKED(pll), .SAG_EVT(evt[0]),
    .RAIL_DELTA_EVT(evt[1]), .RAIL_MEAS_RDY(evt[2]), .BATTERY_LOW_EVT(evt[3]),
    .BATTERY_MEAS_RDY(evt[4]), .DC_INPUT_LOW_EVT(evt[5]), .RX_EDGE_WAKE_EVT(evt[6]),
    .SUPPLY_IRQ(irq), .MEAS_STATUS_READ_CLEAR(rd_clr), .SWITCH_ON_MAIN_LOW(sw_main),
    .SWITCH_ON_DC_LOW(sw_dc), .SLEEP_REF_EN(ref_en), .RX_PIN_GPIO(rx_gpio),
    .RX_PIN_SERIAL(rx_serial), .RX_WAKE_EN(rx_wake));

  pmef_core_model pmef_core_model_inst (
    .clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
    .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_wdata(bit_wdata));

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    pmef_core_model_inst.write_reg(a, d);
    // Register outputs update on the landing edge; look once they settle
    @(negedge clk);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    pmef_core_model_inst.read_reg(a, v);
    check(name, exp, v);
  endtask

  // ----------------------------------------
  // Event sources: 0..6 pulses, 7 rail to battery, 8 rail to main
  // ----------------------------------------
  task automatic cause(input int k);
    @(posedge clk);
    if (k < 7) begin
      evt[k] <= 1'h1;
    end else begin
      rail <= (k == 8);
    end
    @(posedge clk);
    evt <= 7'h00;
    @(negedge clk);
  endtask

  task automatic test_reset();
    rd_chk("enable", pmef_pkg::ADDR_ENABLE, 8'h00);
    rd_chk("peripheral_config_status", pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS, 8'h60);
    rd_chk("config", pmef_pkg::ADDR_CONFIG, 8'h00);
    rd_chk("flags", pmef_pkg::ADDR_FLAGS, 8'h00);
    wr_reg(8'hF6, 8'h5A);
    rd_chk("unmapped", 8'hF6, 8'h00);
    check("irq", 8'h00, {7'h00, irq});
    check("gpio", 8'h01, {7'h00, rx_gpio});
  endtask

  // Every source except the receive wake edge (6) alone, first masked then enabled, then cleared
  task automatic test_events();
    int bits[9] = '{5, 3, 3, 2, 2, 0, 0, 1, 7};
    logic [7:0] m;
    for (int en = 0; en < 2; en++) begin
      for (int k = 0; k < 9; k++) begin
        if (k == 6) continue;
        m = 8'h01 << bits[k];
        wr_reg(pmef_pkg::ADDR_ENABLE, en ? m : 8'h00);
        cause(k);
        rd_chk("flag set", pmef_pkg::ADDR_FLAGS, en ? (m | 8'h40) : m);
        check("irq on", 8'(en), {7'h00, irq});
        wr_reg(pmef_pkg::ADDR_FLAGS, 8'h00);
        rd_chk("flag clear", pmef_pkg::ADDR_FLAGS, 8'h00);
        check("irq off", 8'h00, {7'h00, irq});
      end
    end
    wr_reg(pmef_pkg::ADDR_ENABLE, 8'h00);
  endtask

  task automatic test_flag_writes();
    pmef_core_model_inst.write_bit(3'h3, 1'h1);
    rd_chk("bit set", pmef_pkg::ADDR_FLAGS, 8'h08);
    pmef_core_model_inst.write_bit(3'h3, 1'h0);
    rd_chk("bit clear", pmef_pkg::ADDR_FLAGS, 8'h00);
    cause(0);
    // Clearing write lands on the same edge as a new sag event
    fork
      wr_reg(pmef_pkg::ADDR_FLAGS, 8'h00);
      cause(0);
    join
    rd_chk("set wins", pmef_pkg::ADDR_FLAGS, 8'h20);
    // Byte write and bit write on the same edge: the byte write wins
    fork
      wr_reg(pmef_pkg::ADDR_FLAGS, 8'h04);
      pmef_core_model_inst.write_bit(3'h3, 1'h1);
    join
    rd_chk("byte wins", pmef_pkg::ADDR_FLAGS, 8'h04);
    wr_reg(pmef_pkg::ADDR_FLAGS, 8'h00);
  endtask

  task automatic test_policy();
    for (int p = 0; p < 4; p++) begin
      wr_reg(pmef_pkg::ADDR_CONFIG, 8'(p));
      rd_chk("config", pmef_pkg::ADDR_CONFIG, 8'(p));
      check("main low", {7'h00, p < 2}, {7'h00, sw_main});
      check("dc low", {7'h00, p == 1}, {7'h00, sw_dc});
    end
  endtask

  task automatic test_peripheral_config_status();
    wr_reg(pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS, 8'h0B);
    check("rx pins", 8'h0B, {4'h0, ref_en, rx_gpio, rx_wake, rx_serial});
    cause(6);
    rd_chk("rx woke", pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS, 8'hEB);
    wr_reg(pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS, 8'h01);
    cause(6);
    rd_chk("no wake", pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS, 8'h61);
    check("rx pins", 8'h01, {4'h0, ref_en, rx_gpio, rx_wake, rx_serial});
    @(posedge clk);
    pll <= 1'h1;
    main_ok <= 1'h0;
    cause(7);
    rd_chk("status", pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS, 8'h11);
    cause(8);
    @(posedge clk);
    pll <= 1'h0;
    main_ok <= 1'h1;
    wr_reg(pmef_pkg::ADDR_FLAGS, 8'h00);
    wr_reg(pmef_pkg::ADDR_ENABLE, 8'h40);
    check("read clear", 8'h01, {7'h00, rd_clr});
    rd_chk("no irq src", pmef_pkg::ADDR_FLAGS, 8'h00);
  endtask

  // Frozen clock enable drops events and writes; then a mid-run reset
  task automatic test_freeze();
    wr_reg(pmef_pkg::ADDR_ENABLE, 8'h20);
    cause(0);
    @(posedge clk);
    ce <= 1'h0;
    cause(3);
    wr_reg(pmef_pkg::ADDR_FLAGS, 8'h00);
    check("frozen irq", 8'h01, {7'h00, irq});
    @(posedge clk);
    ce <= 1'h1;
    rd_chk("frozen flags", pmef_pkg::ADDR_FLAGS, 8'h60);
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    rd_chk("reset flags", pmef_pkg::ADDR_FLAGS, 8'h00);
    rd_chk("reset enable", pmef_pkg::ADDR_ENABLE, 8'h00);
    rd_chk("reset peripheral_config_status", pmef_pkg::ADDR_PERIPHERAL_CONFIG_STATUS, 8'h60);
    check("reset irq", 8'h00, {7'h00, irq});
  endtask

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial begin
    nrst = 1'h0;
    ce = 1'h1;
    rail = 1'h1;
    main_ok = 1'h1;
    pll = 1'h0;
    evt = 7'h00;
    errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    test_reset();
    test_events();
    test_flag_writes();
    test_policy();
    test_peripheral_config_status();
    test_freeze();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
